// File: hdl/scss_pkg.sv
package scss_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ         = 40_000_000;  // mclk rate
    localparam int unsigned LOCK_TIME_US   = 2000;        // multiplier lock, typical 2 ms
    localparam int unsigned LOCK_CYCLES    = LOCK_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [10:0] OST_EDGES      = 11'h400;     // start-up wait, 1024 input edges
    localparam logic [10:0] SYNC_EDGES     = 11'h008;     // eight target edges
    // register map
    localparam logic [3:0]  SEL_REG_ADDR   = 4'h0;        // clock select register
    localparam int unsigned SEL_BIT        = 0;           // select bit position
    localparam logic        SEL_RESET      = 1'h0;        // select bit after reset
    // primary mode encodings
    localparam logic [2:0]  MODE_LP        = 3'h0;        // low power crystal
    localparam logic [2:0]  MODE_XT        = 3'h1;        // standard crystal
    localparam logic [2:0]  MODE_HS        = 3'h2;        // high speed crystal
    localparam logic [2:0]  MODE_RC        = 3'h3;        // resistor capacitor
    localparam logic [2:0]  MODE_EC        = 3'h4;        // external clock
    localparam logic [2:0]  MODE_EXTERNAL_CLOCK_GPIO_MODE      = 3'h5;        // external clock, gpio pin
    localparam logic [2:0]  MODE_HSPLL     = 3'h6;        // high speed with multiplier
    localparam logic [2:0]  MODE_RESISTOR_CAPACITOR_GPIO_MODE      = 3'h7;        // resistor capacitor, gpio pin

    // switch sequencer states
    typedef enum logic [6:0] {
        ST_BOOT   = 7'h01,  // first cycle after reset
        ST_RUN    = 7'h02,  // processor running
        ST_FREEZE = 7'h04,  // waiting for first quarter phase
        ST_OST    = 7'h08,  // oscillator start-up wait
        ST_LOCK   = 7'h10,  // multiplier lock wait
        ST_SYNC   = 7'h20,  // counting target edges
        ST_MUX    = 7'h40   // waiting for both clocks low
    } scss_state_t;

    // register port request
    typedef struct packed {
        logic       wr;     // write strobe
        logic       rd;     // read strobe
        logic [3:0] addr;   // register address
        logic [7:0] wdata;  // write data
    } scss_bus_t;

    // two-signal pin drive
    typedef struct packed {
        logic out;          // level driven
        logic oe;           // high while driving
    } scss_pin_t;

    function automatic logic is_crystal(input logic [2:0] m);
        return (m == MODE_LP) || (m == MODE_XT) || (m == MODE_HS) || (m == MODE_HSPLL);
    endfunction : is_crystal

    function automatic logic is_gpio(input logic [2:0] m);
        return (m == MODE_RESISTOR_CAPACITOR_GPIO_MODE) || (m == MODE_EXTERNAL_CLOCK_GPIO_MODE);
    endfunction : is_gpio

    function automatic logic uses_mult(input logic [2:0] m);
        return m == MODE_HSPLL;
    endfunction : uses_mult
endpackage : scss_pkg

// File: hdl/scss_edge_count.sv
`timescale 1ns/100ps
// counts rising edges of a sampled clock level
module scss_edge_count (
    input  wire logic        mclk,     // system clock
    input  wire logic        rst_n,    // sync reset, low
    input  wire logic        clear,    // restart count
    input  wire logic        clk_lvl,  // sampled source level
    output logic      [10:0] cnt_q     // edges seen
);
    logic prev_q;  // level one cycle ago

    // previous level for edge detect
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= clk_lvl;
        end
    end

    // counter saturates so a stalled sequencer cannot wrap it
    always_ff @(posedge mclk) begin
        if (!rst_n || clear) begin
            cnt_q <= 11'h000;
        end else if (clk_lvl && !prev_q && cnt_q != 11'h7ff) begin
            cnt_q <= cnt_q + 11'h001;
        end
    end
endmodule : scss_edge_count

// File: hdl/scss_quarter.sv
`timescale 1ns/100ps
// quarter phase tracker: divide by four and phase-one pulse
module scss_quarter (
    input  wire logic mclk,     // system clock
    input  wire logic rst_n,    // sync reset, low
    input  wire logic clk_lvl,  // sampled source level
    output logic      div4_q,   // source divided by four
    output logic      q1_q      // pulse on entry to phase one
);
    logic       prev_q;   // level one cycle ago
    logic [1:0] phase_q;  // quarter phase index

    // phase advances on each source rising edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_q  <= 1'b0;
            phase_q <= 2'h0;
            q1_q    <= 1'b0;
        end else begin
            prev_q <= clk_lvl;
            q1_q   <= 1'b0;
            if (clk_lvl && !prev_q) begin
                phase_q <= phase_q + 2'h1;
                q1_q    <= (phase_q == 2'h3);
            end
        end
    end

    // divided output toggles every two source edges
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div4_q <= 1'b0;
        end else begin
            div4_q <= phase_q[1];
        end
    end
endmodule : scss_quarter

// File: hdl/scss_top.sv
`timescale 1ns/100ps
module scss_top #(
    parameter int unsigned LOCK_CYCLES = scss_pkg::LOCK_CYCLES  // multiplier lock count
) (
    input  wire logic                mclk,                 // 40 MHz system clock
    input  wire logic                rst_n,                // sync reset, low
    input  wire scss_pkg::scss_bus_t bus_req,              // register port request
    output logic               [7:0] rdata_q,              // read data, cycle after read
    input  wire logic          [2:0] primary_mode_config,  // fixed mode field
    input  wire logic                switch_enable_fuse,   // zero enables switching
    input  wire logic                secondary_osc_enable, // secondary oscillator on
    input  wire logic                osc_input_pin,        // sampled primary input
    input  wire logic                mult_clk_lvl,         // sampled x4 multiplier clock
    input  wire logic                secondary_clk_lvl,    // sampled secondary clock
    input  wire logic                osc_output_pin_in,    // output pin level read back
    input  wire logic                port_a_bit_six_dout,  // port data for the pin
    input  wire logic                port_a_bit_six_oe,    // port drive for the pin
    output scss_pkg::scss_pin_t      osc_pin_q,            // output pin drive
    output logic                     port_a_bit_six_in_q,  // pin level to port
    output logic                     feedback_en_q,        // crystal feedback element on
    output logic                     mult_enable_q,        // multiplier enabled
    output logic                     sys_clk_q,            // selected system clock
    output logic                     active_src_q,         // source in use, 1 secondary
    output logic                     cpu_run_q             // processor may execute
);
    scss_pkg::scss_state_t state_q;         // sequencer state
    logic                  clock_source_select_bit_q;  // software select bit
    logic                  tgt_q;           // source being switched to
    logic                  clr_q;           // restart edge counter
    logic [16:0]           lock_cnt_q;      // lock wait counter
    logic [10:0]           edge_cnt;        // target edges counted
    logic                  pri_src;         // primary system source level
    logic                  cnt_lvl;         // level being counted
    logic                  sel_allow;       // switching permitted now
    logic                  sel_hit;         // access hits select register
    logic                  div4_pri;        // primary divided by four
    logic                  q1_pulse;        // phase one entry of active clock
    logic                  both_low;        // both sources low
    logic                  crystal;         // crystal style primary

    // multiplier output replaces the input only in its own mode
    assign pri_src   = scss_pkg::uses_mult(primary_mode_config) ? mult_clk_lvl
                                                                 : osc_input_pin;
    assign crystal   = scss_pkg::is_crystal(primary_mode_config);
    assign sel_allow = !switch_enable_fuse && secondary_osc_enable;
    assign sel_hit   = bus_req.addr == scss_pkg::SEL_REG_ADDR;
    assign both_low  = !pri_src && !secondary_clk_lvl;
    // start-up wait counts the raw input, sync counts the target
    assign cnt_lvl   = (state_q == scss_pkg::ST_OST) ? osc_input_pin
                     : (tgt_q ? secondary_clk_lvl : pri_src);

    scss_edge_count u_edge (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clear   (clr_q),
        .clk_lvl (cnt_lvl),
        .cnt_q   (edge_cnt)
    );

    scss_quarter u_pri_div (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clk_lvl (osc_input_pin),
        .div4_q  (div4_pri),
        .q1_q    ()
    );

    scss_quarter u_sys_phase (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clk_lvl (sys_clk_q),
        .div4_q  (),
        .q1_q    (q1_pulse)
    );

    // select bit: held clear whenever switching is not permitted
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clock_source_select_bit_q <= scss_pkg::SEL_RESET;
        end else if (!sel_allow) begin
            clock_source_select_bit_q <= 1'b0;
        end else if (bus_req.wr && sel_hit) begin
            clock_source_select_bit_q <= bus_req.wdata[scss_pkg::SEL_BIT];
        end
    end

    // read data; unmapped addresses and upper bits read zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (bus_req.rd && sel_hit) begin
            rdata_q <= {7'h00, clock_source_select_bit_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // switch sequencer: freeze, wait, count edges, swap at a low point
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q      <= scss_pkg::ST_BOOT;
            tgt_q        <= 1'b0;
            active_src_q <= 1'b0;
            cpu_run_q    <= 1'b0;
            clr_q        <= 1'b1;
        end else begin
            clr_q <= 1'b0;
            case (state_q)
                scss_pkg::ST_BOOT: begin
                    // external clock and rc start with no start-up wait
                    if (crystal) begin
                        state_q <= scss_pkg::ST_OST;
                        clr_q   <= 1'b1;
                    end else begin
                        state_q   <= scss_pkg::ST_RUN;
                        cpu_run_q <= 1'b1;
                    end
                end
                scss_pkg::ST_RUN: begin
                    if (clock_source_select_bit_q != active_src_q) begin
                        tgt_q   <= clock_source_select_bit_q;
                        state_q <= scss_pkg::ST_FREEZE;
                    end
                end
                scss_pkg::ST_FREEZE: begin
                    // the processor stops only at a clean phase-one boundary
                    if (q1_pulse) begin
                        cpu_run_q <= 1'b0;
                        clr_q     <= 1'b1;
                        if (!tgt_q && crystal) begin
                            state_q <= scss_pkg::ST_OST;
                        end else begin
                            state_q <= scss_pkg::ST_SYNC;
                        end
                    end
                end
                scss_pkg::ST_OST: begin
                    if (edge_cnt == scss_pkg::OST_EDGES) begin
                        clr_q <= 1'b1;
                        if (scss_pkg::uses_mult(primary_mode_config)) begin
                            state_q <= scss_pkg::ST_LOCK;
                        end else begin
                            state_q <= scss_pkg::ST_SYNC;
                        end
                    end
                end
                scss_pkg::ST_LOCK: begin
                    if (lock_cnt_q == 17'(LOCK_CYCLES - 1)) begin
                        state_q <= scss_pkg::ST_SYNC;
                        clr_q   <= 1'b1;
                    end
                end
                scss_pkg::ST_SYNC: begin
                    if (edge_cnt == scss_pkg::SYNC_EDGES) begin
                        state_q <= scss_pkg::ST_MUX;
                    end
                end
                scss_pkg::ST_MUX: begin
                    // swapping while both are low keeps every pulse whole
                    if (both_low) begin
                        active_src_q <= tgt_q;
                        state_q      <= scss_pkg::ST_RUN;
                        cpu_run_q    <= 1'b1;
                    end
                end
                default: begin
                    state_q   <= scss_pkg::ST_BOOT;
                    cpu_run_q <= 1'b0;
                end
            endcase
        end
    end

    // lock timer runs only in its state
    always_ff @(posedge mclk) begin
        if (!rst_n || state_q != scss_pkg::ST_LOCK) begin
            lock_cnt_q <= 17'h00000;
        end else begin
            lock_cnt_q <= lock_cnt_q + 17'h00001;
        end
    end

    // system clock mux follows the swapped select only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sys_clk_q <= 1'b0;
        end else begin
            sys_clk_q <= active_src_q ? secondary_clk_lvl : pri_src;
        end
    end

    // oscillator pin and analogue controls from the mode field
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            osc_pin_q           <= '0;
            port_a_bit_six_in_q <= 1'b0;
            feedback_en_q       <= 1'b0;
            mult_enable_q       <= 1'b0;
        end else begin
            feedback_en_q <= crystal;
            mult_enable_q <= scss_pkg::uses_mult(primary_mode_config);
            port_a_bit_six_in_q <= scss_pkg::is_gpio(primary_mode_config) & osc_output_pin_in;
            if (scss_pkg::is_gpio(primary_mode_config)) begin
                // pin belongs to the port in gpio modes
                osc_pin_q.out <= port_a_bit_six_dout;
                osc_pin_q.oe  <= port_a_bit_six_oe;
            end else if (!crystal) begin
                osc_pin_q.out <= div4_pri;
                osc_pin_q.oe  <= 1'b1;
            end else begin
                // crystal sits on the pin; an external clock may drive the input
                osc_pin_q <= '0;
            end
        end
    end

    logic both_low_d;  // helper: both low last cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            both_low_d <= 1'b0;
        end else begin
            both_low_d <= both_low;
        end
    end

    a_sel_forced_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        !sel_allow |=> !clock_source_select_bit_q)
        else $error("select bit set while switching not allowed");
    a_reserved_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        rdata_q[7:1] == 7'h00)
        else $error("reserved select register bits not zero");
    a_read_select_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus_req.rd && sel_hit) |=> rdata_q[0] == $past(clock_source_select_bit_q))
        else $error("select bit read back wrong");
    a_freeze_at_q1: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == scss_pkg::ST_FREEZE && q1_pulse) |=> !cpu_run_q)
        else $error("processor not frozen at phase one");
    a_sync_eight_edges: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == scss_pkg::ST_SYNC) ##1 (state_q == scss_pkg::ST_MUX)
        |-> $past(edge_cnt) == scss_pkg::SYNC_EDGES)
        else $error("sync left before eight edges");
    a_ost_full_count: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == scss_pkg::ST_OST) ##1 (state_q != scss_pkg::ST_OST)
        |-> $past(edge_cnt) == scss_pkg::OST_EDGES)
        else $error("start-up wait shorter than 1024 edges");
    a_ost_only_crystal: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == scss_pkg::ST_OST |-> crystal)
        else $error("start-up wait in non-crystal mode");
    a_lock_only_mult: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == scss_pkg::ST_LOCK |-> mult_enable_q && !cpu_run_q)
        else $error("lock wait outside multiplier mode or while running");
    a_mux_swap_low: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(active_src_q) |-> both_low_d)
        else $error("clock mux swapped while a source was high");
    a_pin_driven_div: assert property (@(posedge mclk) disable iff (!rst_n)
        (!crystal && !scss_pkg::is_gpio(primary_mode_config)) |=> osc_pin_q.oe)
        else $error("divided clock not driven on output pin");

    c_to_secondary: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(active_src_q));
    c_to_primary: cover property (@(posedge mclk) disable iff (!rst_n)
        $fell(active_src_q));
    c_lock_done: cover property (@(posedge mclk) disable iff (!rst_n)
        (state_q == scss_pkg::ST_LOCK) ##1 (state_q == scss_pkg::ST_SYNC));
endmodule : scss_top

// File: verification/scss_osc_model.sv
`timescale 1ns/100ps
// free-running oscillator levels as seen by the sampling block
module scss_osc_model #(
    parameter int P_HALF = 4,  // primary half period, mclk cycles
    parameter int S_HALF = 8   // secondary half period, slower source
) (
    input  wire logic mclk,              // system clock
    input  wire logic sec_on,            // secondary oscillator enabled
    output logic      osc_input_pin,     // primary clock level
    output logic      mult_clk_lvl,      // x4 multiplier level
    output logic      secondary_clk_lvl  // secondary clock level
);
    int p_cnt = 0;  // primary phase
    int s_cnt = 0;  // secondary phase
    // an external clock drives the input pin in every mode, crystals too
    always_ff @(posedge mclk) begin
        p_cnt <= (p_cnt + 1) % (2 * P_HALF);
        // a stopped secondary oscillator rests low
        s_cnt <= sec_on ? (s_cnt + 1) % (2 * S_HALF) : 0;
    end
    assign osc_input_pin     = (p_cnt >= P_HALF);
    assign mult_clk_lvl      = 1'(((p_cnt * 4) / P_HALF) % 2);
    assign secondary_clk_lvl = (s_cnt >= S_HALF);
endmodule : scss_osc_model

// File: verification/system_clock_source_switch_tb.sv
`timescale 1ns/100ps
module system_clock_source_switch_tb;
    localparam int LOCK = 200;  // shortened lock count
    logic                mclk, rst_n, fuse, sec_en, osc_in, mult_lvl, sec_lvl;
    logic                pin_in, pa_dout, pa_oe, pa_in, fb_en, mult_en;
    logic                sys_clk, active_src, cpu_run;
    logic          [7:0] rdata_q;
    logic          [2:0] mode;
    scss_pkg::scss_bus_t bus_req;
    scss_pkg::scss_pin_t osc_pin;
    int                  mismatches = 0;
    int                  cmp_count = 0;
    int                  cyc, pe, se, lo, tg;
    logic                xtal, prev;

    scss_top #(.LOCK_CYCLES(LOCK)) scss_top_i (.mclk(mclk), .rst_n(rst_n),
        .bus_req(bus_req), .rdata_q(rdata_q), .primary_mode_config(mode),
        .switch_enable_fuse(fuse), .secondary_osc_enable(sec_en),
        .osc_input_pin(osc_in), .mult_clk_lvl(mult_lvl), .secondary_clk_lvl(sec_lvl),
        .osc_output_pin_in(pin_in), .port_a_bit_six_dout(pa_dout),
        .port_a_bit_six_oe(pa_oe), .osc_pin_q(osc_pin), .port_a_bit_six_in_q(pa_in),
        .feedback_en_q(fb_en), .mult_enable_q(mult_en), .sys_clk_q(sys_clk),
        .active_src_q(active_src), .cpu_run_q(cpu_run));
    scss_osc_model scss_osc_model_i (.mclk(mclk), .sec_on(sec_en), .osc_input_pin(osc_in),
        .mult_clk_lvl(mult_lvl), .secondary_clk_lvl(sec_lvl));
    // pin level: driver wins, else a weak pull-up
    assign pin_in = osc_pin.oe ? osc_pin.out : 1'h1;

    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // range check on a measured count, not on a design value
    task automatic rng(input int v, input int l, input int h);
        chk(16'((v >= l) && (v <= h)), 16'h0001);
    endtask : rng

    task automatic do_reset(input logic [2:0] m);
        rst_n   <= 1'h0;
        mode    <= m;
        bus_req <= '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'h1;
    endtask : do_reset

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge mclk);
        bus_req <= '0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        bus_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        chk(16'(rdata_q), 16'(e));
    endtask : rd_reg

    // waits for the freeze unless from_reset is set, then counts cycles and source edges to resume
    task automatic measure(input logic from_reset);
        logic p0, s0;
        cyc = 0;
        pe = 0;
        se = 0;
        while (!from_reset && cpu_run !== 1'h0 && cyc < 200) begin
            @(posedge mclk);
            #1;
            cyc++;
        end
        cyc = 0;
        p0 = osc_in;
        s0 = sec_lvl;
        while (cpu_run !== 1'h1 && cyc < 20000) begin
            @(posedge mclk);
            #1;
            cyc++;
            pe += int'(osc_in && !p0);
            se += int'(sec_lvl && !s0);
            p0 = osc_in;
            s0 = sec_lvl;
        end
    endtask : measure

    task automatic give_verdict();
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    // watchdog sized above the longest start-up sequences
    initial begin
        repeat (80000) @(posedge mclk);
        mismatches++;
        give_verdict();
    end

    initial begin
        rst_n   = 1'h0;
        fuse    = 1'h0;
        sec_en  = 1'h1;
        pa_dout = 1'h1;
        pa_oe   = 1'h1;
        mode    = scss_pkg::MODE_RC;
        bus_req = '0;
        // every mode: pin use, feedback, multiplier, start-up hold
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            repeat (3) @(posedge mclk);
            #1;
            xtal = (m <= 2) || (3'(m) == scss_pkg::MODE_HSPLL);
            tg   = int'(3'(m) == scss_pkg::MODE_RESISTOR_CAPACITOR_GPIO_MODE || 3'(m) == scss_pkg::MODE_EXTERNAL_CLOCK_GPIO_MODE);
            chk(16'(fb_en), 16'(xtal));
            chk(16'(mult_en), 16'(3'(m) == scss_pkg::MODE_HSPLL));
            chk(16'(osc_pin.oe), 16'(!xtal));
            chk(16'(cpu_run), 16'(!xtal));
            chk(16'(pa_in), 16'(tg));
            if (tg == 1) chk(16'(osc_pin.out), 16'h0001);
            if (!xtal && tg == 0) begin
                // divided clock toggles every 16 cycles at the model rate
                pe   = 0;
                prev = osc_pin.out;
                repeat (64) begin
                    @(posedge mclk);
                    #1;
                    pe += int'(osc_pin.out !== prev);
                    prev = osc_pin.out;
                end
                chk(16'(pe), 16'h0004);
            end
        end
        // select bit access and refusal
        do_reset(scss_pkg::MODE_RC);
        rd_reg(4'h0, 8'h00);
        fuse <= 1'h1;
        wr_reg(4'h0, 8'h01);
        rd_reg(4'h0, 8'h00);
        fuse   <= 1'h0;
        sec_en <= 1'h0;
        wr_reg(4'h0, 8'h01);
        rd_reg(4'h0, 8'h00);
        sec_en <= 1'h1;
        wr_reg(4'h3, 8'hff);
        rd_reg(4'h3, 8'h00);
        wr_reg(4'h0, 8'hff);
        rd_reg(4'h0, 8'h01);
        measure(1'h0);
        rng(se, 8, 9);
        chk(16'(active_src), 16'h0001);
        prev = sec_lvl;
        repeat (20) begin
            @(posedge mclk);
            #1;
            chk(16'(sys_clk), 16'(prev));
            prev = sec_lvl;
        end
        wr_reg(4'h0, 8'h00);
        measure(1'h0);
        rng(pe, 8, 9);
        rng(cyc, 56, 110);
        chk(16'(active_src), 16'h0000);
        // dropping the enable forces the bit clear
        wr_reg(4'h0, 8'h01);
        sec_en <= 1'h0;
        rd_reg(4'h0, 8'h00);
        sec_en <= 1'h1;
        wr_reg(4'h0, 8'h01);
        do_reset(scss_pkg::MODE_RC);
        rd_reg(4'h0, 8'h00);
        // crystal returns: start-up wait, lock only with the multiplier
        for (int k = 0; k < 2; k++) begin
            do_reset(k == 0 ? scss_pkg::MODE_HS : scss_pkg::MODE_HSPLL);
            lo = 8184 + k * LOCK;
            measure(1'h1);
            rng(cyc, lo, lo + 120);
            wr_reg(4'h0, 8'h01);
            measure(1'h0);
            rng(se, 8, 9);
            wr_reg(4'h0, 8'h00);
            measure(1'h0);
            rng(cyc, lo, lo + 120);
        end
        give_verdict();
    end
endmodule : system_clock_source_switch_tb
